// *** include/line_regs_pkg.sv ***
// How it works
// - On-time count is 16 bits at addresses 29 and 30, 1.25 us per step.
// - Off-time count is 16 bits at addresses 31 and 32, same step.
// - Bit 3 of polarity control reads line polarity: 0 forward, 1 reverse.
// - Wink bit ramps open-circuit voltage to 0 V; clear keeps normal voltage.
// - Gradual polarity reversal happens only while the smooth enable bit is one.
// - Smooth ramp moves 1 V per 1.25 ms, or 2 V when slew select is one.
// - Data registers then address write stores data at the next memory update.
// - Address write alone loads RAM contents into data registers one clock after the next update.
// - Indirect address and data registers are one copy shared by both channels.
// - Timer bytes, polarity control and data high byte reset to zero.
// - Busy bit 0 at address 4 is high while a RAM access is pending.
// - Data low byte sits at address 101, high byte at 102.
// - On, off and metering enables gate the timers and the metering itself.
package line_regs_pkg;

	// ============================================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int METER_STEP_NS = 1250;
	localparam int METER_STEP_CYCLES = (METER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int METER_CNT_W = $clog2(METER_STEP_CYCLES);
	localparam int RAMP_STEP_US = 1250;
	localparam int RAMP_STEP_CYCLES = RAMP_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int MEM_UPDATE_NS = 125000;
	localparam int MEM_UPDATE_CYCLES = MEM_UPDATE_NS / CLK_PERIOD_NS;
	localparam int MEM_CNT_W = $clog2(MEM_UPDATE_CYCLES);

	// ============================================================
	// Structure
	localparam int NUM_CH = 2;
	localparam int RAM_ADDR_W = 8;
	localparam int RAM_DATA_W = 16;

	// ============================================================
	// Register addresses
	localparam logic [7:0] ADDR_RAM_STATUS = 8'h04;
	localparam logic [7:0] ADDR_POL_CTRL = 8'h07;
	localparam logic [7:0] ADDR_METER_CTRL = 8'h1C;
	localparam logic [7:0] ADDR_ON_LOW = 8'h1D;
	localparam logic [7:0] ADDR_ON_HIGH = 8'h1E;
	localparam logic [7:0] ADDR_OFF_LOW = 8'h1F;
	localparam logic [7:0] ADDR_OFF_HIGH = 8'h20;
	localparam logic [7:0] ADDR_DATA_LOW = 8'h65;
	localparam logic [7:0] ADDR_DATA_HIGH = 8'h66;
	localparam logic [7:0] ADDR_INDIRECT = 8'h67;

	// ============================================================
	// Field positions
	localparam int BUSY_BIT = 0;
	localparam int POL_STATUS_BIT = 3;
	localparam int WINK_BIT = 2;
	localparam int SMOOTH_BIT = 1;
	localparam int SLEW_BIT = 0;
	localparam int METER_PRESENT_BIT = 7;
	localparam int ON_EN_BIT = 4;
	localparam int OFF_EN_BIT = 3;
	localparam int METER_EN_BIT = 2;

	// ============================================================
	// Values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [7:0] SLEW_SLOW_V = 8'h01;
	localparam logic [7:0] SLEW_FAST_V = 8'h02;

	// ============================================================
	// States
	typedef enum logic [1:0] {
		RAM_IDLE = 2'b00,
		RAM_PEND_WR = 2'b01,
		RAM_PEND_RD = 2'b10,
		RAM_LOAD = 2'b11
	} ram_state_t;

	typedef enum logic [1:0] {
		MC_IDLE = 2'b00,
		MC_BURST = 2'b01,
		MC_GAP = 2'b10,
		MC_DONE = 2'b11
	} meter_state_t;

endpackage : line_regs_pkg

// *** src/indirect_ram.sv ***
`timescale 1ns/10ps
module indirect_ram
	import line_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic we,
	input wire logic re,
	input wire logic [RAM_ADDR_W-1:0] addr,
	input wire logic [RAM_DATA_W-1:0] wdata,
	output logic [RAM_DATA_W-1:0] rdata_q
);

	// Array has no reset so it can map onto a plain memory macro.
	logic [RAM_DATA_W-1:0] mem [2**RAM_ADDR_W];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= RESET_WORD;
		end else if (re) begin
			rdata_q <= mem[addr];
		end
	end

endmodule : indirect_ram

// *** src/metering_cadence.sv ***
`timescale 1ns/10ps
module metering_cadence
	import line_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic step_tick,
	input wire logic run,
	input wire logic on_timed,
	input wire logic off_timed,
	input wire logic [15:0] on_count,
	input wire logic [15:0] off_count,
	output logic burst_q
);

	meter_state_t state_q;
	logic [15:0] count_q;
	logic expired;

	// A count of zero or one ends the phase at the first step.
	assign expired = step_tick && (count_q <= 16'h0001);

	// ============================================================
	// Cadence
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= MC_IDLE;
			count_q <= RESET_WORD;
			burst_q <= 1'b0;
		end else if (!run) begin
			state_q <= MC_IDLE;
			burst_q <= 1'b0;
		end else begin
			unique case (state_q)
				MC_IDLE: begin
					state_q <= MC_BURST;
					count_q <= on_count;
					burst_q <= 1'b1;
				end
				MC_BURST: begin
					if (on_timed && expired) begin
						burst_q <= 1'b0;
						count_q <= off_count;
						state_q <= off_timed ? MC_GAP : MC_DONE;
					end else if (on_timed && step_tick) begin
						count_q <= count_q - 16'h0001;
					end
				end
				MC_GAP: begin
					if (off_timed && expired) begin
						burst_q <= 1'b1;
						count_q <= on_count;
						state_q <= MC_BURST;
					end else if (off_timed && step_tick) begin
						count_q <= count_q - 16'h0001;
					end
				end
				MC_DONE: begin
					burst_q <= 1'b0;
				end
			endcase
		end
	end

endmodule : metering_cadence

// *** src/metering_polarity_ram_regs.sv ***
`timescale 1ns/10ps
module metering_polarity_ram_regs
	import line_regs_pkg::*;
#(
	parameter int RAMP_STEP_CYCLES_P = RAMP_STEP_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic reg_chan,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	input wire logic [NUM_CH-1:0] polarity_request,
	input wire logic [7:0] voc_target [NUM_CH],
	output logic [NUM_CH-1:0] line_polarity_status,
	output logic [7:0] voc_level_q [NUM_CH],
	output logic [NUM_CH-1:0] metering_burst
);

	localparam int RAMP_CNT_W = $clog2(RAMP_STEP_CYCLES_P + 1);
	localparam logic [RAMP_CNT_W-1:0] RAMP_LAST = RAMP_CNT_W'(RAMP_STEP_CYCLES_P - 1);
	localparam logic [METER_CNT_W-1:0] METER_LAST = METER_CNT_W'(METER_STEP_CYCLES - 1);
	localparam logic [MEM_CNT_W-1:0] MEM_LAST = MEM_CNT_W'(MEM_UPDATE_CYCLES - 1);

	// ============================================================
	// Time bases
	logic [METER_CNT_W-1:0] meter_cnt_q;
	logic [RAMP_CNT_W-1:0] ramp_cnt_q;
	logic [MEM_CNT_W-1:0] mem_cnt_q;
	logic meter_tick;
	logic ramp_tick;
	logic mem_tick;

	assign meter_tick = (meter_cnt_q == METER_LAST);
	assign ramp_tick = (ramp_cnt_q == RAMP_LAST);
	assign mem_tick = (mem_cnt_q == MEM_LAST);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meter_cnt_q <= '0;
		end else begin
			meter_cnt_q <= meter_tick ? '0 : meter_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ramp_cnt_q <= '0;
		end else begin
			ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mem_cnt_q <= '0;
		end else begin
			mem_cnt_q <= mem_tick ? '0 : mem_cnt_q + 1'b1;
		end
	end

	// ============================================================
	// Per-channel registers
	logic [7:0] on_low_q [NUM_CH];
	logic [7:0] on_high_q [NUM_CH];
	logic [7:0] off_low_q [NUM_CH];
	logic [7:0] off_high_q [NUM_CH];
	logic [2:0] pol_ctrl_q [NUM_CH];
	logic [2:0] meter_ctrl_q [NUM_CH];
	logic [1:0] on_seen_q [NUM_CH];
	logic [1:0] off_seen_q [NUM_CH];
	logic [15:0] on_count_q [NUM_CH];
	logic [15:0] off_count_q [NUM_CH];
	logic [NUM_CH-1:0] chan_wr;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			chan_wr[c] = reg_wr && (reg_chan == 1'(c));
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				on_low_q[c] <= RESET_BYTE;
				on_high_q[c] <= RESET_BYTE;
				off_low_q[c] <= RESET_BYTE;
				off_high_q[c] <= RESET_BYTE;
				pol_ctrl_q[c] <= RESET_BYTE[2:0];
				meter_ctrl_q[c] <= RESET_BYTE[2:0];
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (chan_wr[c]) begin
					unique case (reg_addr)
						ADDR_ON_LOW: on_low_q[c] <= reg_wdata;
						ADDR_ON_HIGH: on_high_q[c] <= reg_wdata;
						ADDR_OFF_LOW: off_low_q[c] <= reg_wdata;
						ADDR_OFF_HIGH: off_high_q[c] <= reg_wdata;
						ADDR_POL_CTRL: begin
							pol_ctrl_q[c] <= {reg_wdata[WINK_BIT], reg_wdata[SMOOTH_BIT], reg_wdata[SLEW_BIT]};
						end
						ADDR_METER_CTRL: begin
							meter_ctrl_q[c] <= {reg_wdata[ON_EN_BIT], reg_wdata[OFF_EN_BIT], reg_wdata[METER_EN_BIT]};
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				on_seen_q[c] <= 2'h0;
				off_seen_q[c] <= 2'h0;
				on_count_q[c] <= RESET_WORD;
				off_count_q[c] <= RESET_WORD;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (on_seen_q[c] == 2'h3) begin
					on_count_q[c] <= {on_high_q[c], on_low_q[c]};
					on_seen_q[c] <= {chan_wr[c] && reg_addr == ADDR_ON_HIGH, chan_wr[c] && reg_addr == ADDR_ON_LOW};
				end else if (chan_wr[c] && reg_addr == ADDR_ON_LOW) begin
					on_seen_q[c] <= on_seen_q[c] | 2'h1;
				end else if (chan_wr[c] && reg_addr == ADDR_ON_HIGH) begin
					on_seen_q[c] <= on_seen_q[c] | 2'h2;
				end
				if (off_seen_q[c] == 2'h3) begin
					off_count_q[c] <= {off_high_q[c], off_low_q[c]};
					off_seen_q[c] <= {chan_wr[c] && reg_addr == ADDR_OFF_HIGH, chan_wr[c] && reg_addr == ADDR_OFF_LOW};
				end else if (chan_wr[c] && reg_addr == ADDR_OFF_LOW) begin
					off_seen_q[c] <= off_seen_q[c] | 2'h1;
				end else if (chan_wr[c] && reg_addr == ADDR_OFF_HIGH) begin
					off_seen_q[c] <= off_seen_q[c] | 2'h2;
				end
			end
		end
	end

	// ============================================================
	// Metering cadence
	for (genvar c = 0; c < NUM_CH; c++) begin : g_meter
		metering_cadence u_cadence (
			.mclk(mclk),
			.rstn(rstn),
			.step_tick(meter_tick),
			.run(meter_ctrl_q[c][0]),
			.on_timed(meter_ctrl_q[c][2]),
			.off_timed(meter_ctrl_q[c][1]),
			.on_count(on_count_q[c]),
			.off_count(off_count_q[c]),
			.burst_q(metering_burst[c])
		);
	end

	// ============================================================
	// Polarity and open-circuit voltage
	logic [NUM_CH-1:0] pol_q;
	logic [NUM_CH-1:0] reversing;
	logic [7:0] voc_goal [NUM_CH];
	logic [7:0] voc_step [NUM_CH];

	assign line_polarity_status = pol_q;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			reversing[c] = polarity_request[c] != pol_q[c];
			voc_goal[c] = (pol_ctrl_q[c][2] || (reversing[c] && pol_ctrl_q[c][1])) ? 8'h00 : voc_target[c];
			voc_step[c] = pol_ctrl_q[c][0] ? SLEW_FAST_V : SLEW_SLOW_V;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pol_q <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (reversing[c] && (!pol_ctrl_q[c][1] || voc_level_q[c] == 8'h00)) begin
					pol_q[c] <= polarity_request[c];
				end
			end
		end
	end

	// Saturating steps so a 2 V slew never overshoots an odd goal.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				voc_level_q[c] <= RESET_BYTE;
			end
		end else if (ramp_tick) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (voc_level_q[c] > voc_goal[c]) begin
					voc_level_q[c] <= (voc_level_q[c] - voc_goal[c] > voc_step[c]) ?
						voc_level_q[c] - voc_step[c] : voc_goal[c];
				end else if (voc_level_q[c] < voc_goal[c]) begin
					voc_level_q[c] <= (voc_goal[c] - voc_level_q[c] > voc_step[c]) ?
						voc_level_q[c] + voc_step[c] : voc_goal[c];
				end
			end
		end
	end

	// ============================================================
	// Shared indirect RAM access
	ram_state_t ram_state_q;
	logic [7:0] data_low_q;
	logic [7:0] data_high_q;
	logic [7:0] ind_addr_q;
	logic data_fresh_q;
	logic ram_busy;
	logic host_addr_wr;
	logic host_low_wr;
	logic host_high_wr;
	logic ram_we;
	logic ram_re;
	logic [RAM_DATA_W-1:0] ram_rdata;

	// one copy, channel select ignored
	// Writes while busy are dropped so a pending access keeps its operands.
	assign host_addr_wr = reg_wr && reg_addr == ADDR_INDIRECT && !ram_busy;
	assign host_low_wr = reg_wr && reg_addr == ADDR_DATA_LOW && !ram_busy;
	assign host_high_wr = reg_wr && reg_addr == ADDR_DATA_HIGH && !ram_busy;
	assign ram_busy = (ram_state_q != RAM_IDLE);
	assign ram_we = (ram_state_q == RAM_PEND_WR) && mem_tick;
	assign ram_re = (ram_state_q == RAM_PEND_RD) && mem_tick;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ram_state_q <= RAM_IDLE;
		end else begin
			unique case (ram_state_q)
				RAM_IDLE: begin
					if (host_addr_wr) begin
						ram_state_q <= data_fresh_q ? RAM_PEND_WR : RAM_PEND_RD;
					end
				end
				RAM_PEND_WR: if (mem_tick) ram_state_q <= RAM_IDLE;
				RAM_PEND_RD: if (mem_tick) ram_state_q <= RAM_LOAD;
				RAM_LOAD: ram_state_q <= RAM_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			data_fresh_q <= 1'b0;
		end else if (host_low_wr || host_high_wr) begin
			data_fresh_q <= 1'b1;
		end else if (host_addr_wr) begin
			data_fresh_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			data_low_q <= RESET_BYTE;
			data_high_q <= RESET_BYTE;
			ind_addr_q <= RESET_BYTE;
		end else begin
			if (ram_state_q == RAM_LOAD) begin
				{data_high_q, data_low_q} <= ram_rdata;
			end
			if (host_low_wr) begin
				data_low_q <= reg_wdata;
			end
			if (host_high_wr) begin
				data_high_q <= reg_wdata;
			end
			if (host_addr_wr) begin
				ind_addr_q <= reg_wdata;
			end
		end
	end

	indirect_ram u_ram (
		.mclk(mclk),
		.rstn(rstn),
		.we(ram_we),
		.re(ram_re),
		.addr(ind_addr_q),
		.wdata({data_high_q, data_low_q}),
		.rdata_q(ram_rdata)
	);

	// ============================================================
	// Read path
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = RESET_BYTE;
		unique case (reg_addr)
			ADDR_RAM_STATUS: rd_mux[BUSY_BIT] = ram_busy;
			ADDR_POL_CTRL: begin
				rd_mux[POL_STATUS_BIT] = pol_q[reg_chan];
				rd_mux[WINK_BIT] = pol_ctrl_q[reg_chan][2];
				rd_mux[SMOOTH_BIT] = pol_ctrl_q[reg_chan][1];
				rd_mux[SLEW_BIT] = pol_ctrl_q[reg_chan][0];
			end
			ADDR_METER_CTRL: begin
				rd_mux[METER_PRESENT_BIT] = metering_burst[reg_chan];
				rd_mux[ON_EN_BIT] = meter_ctrl_q[reg_chan][2];
				rd_mux[OFF_EN_BIT] = meter_ctrl_q[reg_chan][1];
				rd_mux[METER_EN_BIT] = meter_ctrl_q[reg_chan][0];
			end
			ADDR_ON_LOW: rd_mux = on_low_q[reg_chan];
			ADDR_ON_HIGH: rd_mux = on_high_q[reg_chan];
			ADDR_OFF_LOW: rd_mux = off_low_q[reg_chan];
			ADDR_OFF_HIGH: rd_mux = off_high_q[reg_chan];
			// data bytes at 101 and 102
			ADDR_DATA_LOW: rd_mux = data_low_q;
			ADDR_DATA_HIGH: rd_mux = data_high_q;
			ADDR_INDIRECT: rd_mux = ind_addr_q;
			default: rd_mux = RESET_BYTE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_q <= RESET_BYTE;
		end else if (reg_rd) begin
			reg_rdata_q <= rd_mux;
		end
	end

endmodule : metering_polarity_ram_regs

// *** verification/mpr_properties.sv ***
`timescale 1ns/10ps
module mpr_properties
	import line_regs_pkg::*;
#(
	parameter int RAMP_STEP_CYCLES_P = RAMP_STEP_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic reg_chan,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic [NUM_CH-1:0] polarity_request,
	input wire logic [NUM_CH-1:0] line_polarity_status,
	input wire logic [7:0] voc_level_q [NUM_CH],
	input wire logic [NUM_CH-1:0] metering_burst
);
	// ==========
	// Shadow state
	// Only channel A is shadowed, apart from pol_rd_q, which follows reg_chan; the bench drives both, but one copy keeps the checker small.
	logic [7:0] ctrl_q;
	logic [7:0] voc_q;
	logic men_q;
	logic req_q;
	logic pol_rd_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= 8'h00;
			men_q <= 1'b0;
		end else if (reg_wr && !reg_chan) begin
			if (reg_addr == ADDR_POL_CTRL) begin
				ctrl_q <= reg_wdata;
			end
			if (reg_addr == ADDR_METER_CTRL) begin
				men_q <= reg_wdata[METER_EN_BIT];
			end
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			voc_q <= 8'h00;
			req_q <= 1'b0;
			pol_rd_q <= 1'b0;
		end else begin
			voc_q <= voc_level_q[0];
			req_q <= polarity_request[0];
			pol_rd_q <= line_polarity_status[reg_chan];
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	property p_rst; $rose(rstn) |-> reg_rdata_q == 8'h00 && metering_burst == 2'h0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	property p_pol_rd; reg_rd && reg_addr == ADDR_POL_CTRL |=> reg_rdata_q[7:3] == {4'h0, pol_rd_q}; endproperty
	a_pol_rd: assert property (p_pol_rd) else $error("polarity status read wrong");
	property p_flip; $changed(line_polarity_status[0]) |-> line_polarity_status[0] == req_q; endproperty
	a_flip: assert property (p_flip) else $error("polarity moved without request");
	property p_abrupt;
		!ctrl_q[SMOOTH_BIT] && polarity_request[0] != line_polarity_status[0] |=> line_polarity_status[0] == req_q;
	endproperty
	a_abrupt: assert property (p_abrupt) else $error("abrupt reversal late");
	property p_smooth; ctrl_q[SMOOTH_BIT] && $changed(line_polarity_status[0]) |-> voc_q == 8'h00; endproperty
	a_smooth: assert property (p_smooth) else $error("smooth reversal above zero volts");
	property p_slew;
		$changed(voc_level_q[0]) |-> ((voc_level_q[0] > voc_q) ? voc_level_q[0] - voc_q : voc_q - voc_level_q[0])
			<= (ctrl_q[SLEW_BIT] ? SLEW_FAST_V : SLEW_SLOW_V);
	endproperty
	a_slew: assert property (p_slew) else $error("ramp step too large");
	property p_wink; ctrl_q[WINK_BIT] && $changed(voc_level_q[0]) |-> voc_level_q[0] < voc_q; endproperty
	a_wink: assert property (p_wink) else $error("voltage rose during wink");
	property p_m_on; $rose(men_q) |=> metering_burst[0]; endproperty
	a_m_on: assert property (p_m_on) else $error("burst did not start");
	property p_m_off; !men_q |=> !metering_burst[0]; endproperty
	a_m_off: assert property (p_m_off) else $error("burst while disabled");
	c_abrupt: cover property (!ctrl_q[SMOOTH_BIT] && $changed(line_polarity_status[0]));
	c_smooth: cover property (ctrl_q[SMOOTH_BIT] && $changed(line_polarity_status[0]));
	c_burst: cover property ($fell(metering_burst[0]) ##[1:200] $rose(metering_burst[0]));
endmodule : mpr_properties

bind metering_polarity_ram_regs mpr_properties #(.RAMP_STEP_CYCLES_P(RAMP_STEP_CYCLES_P)) chk_i (
	.mclk(mclk), .rstn(rstn), .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .polarity_request(polarity_request),
	.line_polarity_status(line_polarity_status), .voc_level_q(voc_level_q), .metering_burst(metering_burst)
);

// *** verification/host_model.sv ***
`timescale 1ns/10ps
module host_model (
	input wire logic mclk,
	input wire logic [7:0] reg_rdata_q,
	output logic reg_chan,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_chan = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// ==========
	// Bus cycles
	// Idle address and data are inverted so the block cannot lean on stale values.
	task automatic wr(input logic ch, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_chan <= ch;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic ch, input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_chan <= ch;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge mclk);
		d = reg_rdata_q;
	endtask : rd
endmodule : host_model

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
	import line_regs_pkg::*;
;
	localparam int RAMP_P = 20;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic reg_chan, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rv;
	logic [NUM_CH-1:0] polarity_request = 2'h0;
	logic [NUM_CH-1:0] line_polarity_status, metering_burst;
	logic [7:0] voc_target [NUM_CH];
	logic [7:0] voc_level_q [NUM_CH];
	logic [7:0] regs [8] = '{ADDR_RAM_STATUS, ADDR_POL_CTRL, ADDR_ON_LOW, ADDR_ON_HIGH, ADDR_OFF_LOW,
		ADDR_OFF_HIGH, ADDR_DATA_HIGH, ADDR_DATA_LOW};
	int err_count = 0;
	int n_tests = 0;
	int n;
	always #25 mclk = ~mclk;
	host_model host (.mclk(mclk), .reg_rdata_q(reg_rdata_q), .reg_chan(reg_chan), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	metering_polarity_ram_regs #(.RAMP_STEP_CYCLES_P(RAMP_P)) dut (.mclk(mclk), .rstn(rstn),
		.reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .polarity_request(polarity_request), .voc_target(voc_target),
		.line_polarity_status(line_polarity_status), .voc_level_q(voc_level_q), .metering_burst(metering_burst));
	// ==========
	// Helpers
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rchk(input string what, input logic ch, input logic [7:0] a, input logic [7:0] exp);
		host.rd(ch, a, rv);
		chk(what, exp, rv);
	endtask : rchk
	// The poll bound covers one memory update period plus read overhead.
	task automatic wait_idle();
		for (int i = 0; i < 2000; i++) begin
			host.rd(1'b0, ADDR_RAM_STATUS, rv);
			if (rv[BUSY_BIT] === 1'b0) break;
		end
		chk("busy clear", 8'h00, rv); // busy ends.
	endtask : wait_idle
	task automatic span(input logic lvl);
		n = 0;
		while (metering_burst[0] === lvl && n < 1000) begin
			@(negedge mclk);
			n++;
		end
	endtask : span
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#3000000;
		err_count++;
		end_sim();
	end
	// ==========
	// Tests
	initial begin
		voc_target[0] = 8'h04;
		voc_target[1] = 8'h06;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		for (int k = 0; k < 7; k++) rchk("reset", 1'b0, regs[k], 8'h00); // zero values.
		$display("test reset done");
		for (int k = 2; k < 8; k++) begin
			host.wr(1'b0, regs[k], 8'hA0 | 8'(k));
			host.wr(1'b1, regs[k], 8'h50 | 8'(k));
			rchk("rw", 1'b0, regs[k], (k > 5) ? (8'h50 | 8'(k)) : (8'hA0 | 8'(k))); // bytes.
		end
		host.wr(1'b1, ADDR_POL_CTRL, 8'hFF);
		rchk("pol ro", 1'b1, ADDR_POL_CTRL, 8'h07); // status read-only.
		rchk("unmapped", 1'b0, 8'h50, 8'h00); // reads zero.
		$display("test registers done");
		host.wr(1'b0, ADDR_DATA_LOW, 8'h34); // data first.
		host.wr(1'b0, ADDR_DATA_HIGH, 8'h12); // data first.
		host.wr(1'b0, ADDR_INDIRECT, 8'h05); // then address.
		rchk("busy set", 1'b0, ADDR_RAM_STATUS, 8'h01); // pending.
		host.wr(1'b0, ADDR_DATA_LOW, 8'hEE);
		wait_idle();
		rchk("dropped", 1'b0, ADDR_DATA_LOW, 8'h34); // write while busy.
		host.wr(1'b0, ADDR_DATA_LOW, 8'hCD);
		host.wr(1'b0, ADDR_DATA_HIGH, 8'hAB);
		host.wr(1'b0, ADDR_INDIRECT, 8'h06); // second word.
		wait_idle();
		host.wr(1'b1, ADDR_INDIRECT, 8'h05); // address alone.
		wait_idle();
		rchk("ram lo", 1'b0, ADDR_DATA_LOW, 8'h34); // loaded.
		rchk("ram hi", 1'b0, ADDR_DATA_HIGH, 8'h12); // loaded.
		rchk("ram addr", 1'b1, ADDR_INDIRECT, 8'h05); // shared address.
		$display("test ram done");
		@(posedge mclk);
		polarity_request[0] <= 1'b1;
		repeat (3) @(posedge mclk);
		rchk("abrupt", 1'b0, ADDR_POL_CTRL, 8'h08); // reverse at once.
		host.wr(1'b0, ADDR_POL_CTRL, 8'h03);
		polarity_request[0] <= 1'b0;
		repeat (3) @(negedge mclk);
		chk("smooth hold", 8'h01, 8'(line_polarity_status[0])); // waits for ramp.
		repeat (200) @(negedge mclk);
		chk("smooth end", 8'h00, 8'(line_polarity_status[0])); // forward again.
		chk("voc back", 8'h04, voc_level_q[0]); // ramps back.
		chk("voc b wink", 8'h00, voc_level_q[1]); // channel B wink.
		$display("test polarity done");
		host.wr(1'b0, ADDR_POL_CTRL, 8'h04);
		n = 0;
		while (voc_level_q[0] !== 8'h00 && n < 500) begin
			@(negedge mclk);
			n++;
		end
		// Four slow steps of RAMP_P cycles, phase of the free-running tick unknown.
		chk("wink time", 8'h01, 8'(n >= 3 * RAMP_P && n <= 4 * RAMP_P + 5)); // one volt steps.
		host.wr(1'b0, ADDR_POL_CTRL, 8'h00);
		repeat (200) @(negedge mclk);
		chk("wink off", 8'h04, voc_level_q[0]); // normal voltage.
		$display("test wink done");
		host.wr(1'b0, ADDR_ON_LOW, 8'h03);
		host.wr(1'b0, ADDR_ON_HIGH, 8'h00);
		host.wr(1'b0, ADDR_OFF_LOW, 8'h05);
		host.wr(1'b0, ADDR_OFF_HIGH, 8'h00);
		host.wr(1'b0, ADDR_ON_LOW, 8'h60); // lone byte must not load.
		host.wr(1'b0, ADDR_METER_CTRL, 8'h1C);
		span(1'b0);
		span(1'b1);
		chk("on span", 8'h01, 8'(n >= 2 * METER_STEP_CYCLES && n <= 4 * METER_STEP_CYCLES));
		span(1'b0);
		chk("off span", 8'h01, 8'(n >= 4 * METER_STEP_CYCLES && n <= 6 * METER_STEP_CYCLES));
		chk("next burst", 8'h01, 8'(metering_burst[0])); // alternates.
		host.wr(1'b0, ADDR_METER_CTRL, 8'h00);
		host.wr(1'b0, ADDR_METER_CTRL, 8'h04);
		repeat (300) @(negedge mclk);
		chk("no timer", 8'h01, 8'(metering_burst[0])); // continuous.
		rchk("meter ctrl", 1'b0, ADDR_METER_CTRL, 8'h84); // present flag and enable.
		chk("meter b", 8'h00, 8'(metering_burst[1])); // channel B stays off.
		host.wr(1'b0, ADDR_METER_CTRL, 8'h00);
		repeat (3) @(negedge mclk);
		chk("meter off", 8'h00, 8'(metering_burst[0])); // stops.
		host.wr(1'b0, ADDR_METER_CTRL, 8'h14);
		repeat (300) @(negedge mclk);
		chk("one shot", 8'h00, 8'(metering_burst[0])); // no off timer.
		$display("test metering done");
		end_sim();
	end
endmodule : tb_top
